// ==== cpti_chk.sv ====
`timescale 1ns/100ps
// Port-level checks of reset parking, bus timing, interrupt pin and PCM
module cpti_chk (
  // Clock and reset
  input logic                          clk,
  input logic                          sys_rst,
  // Bus
  input logic                          wb_cyc_i,
  input logic                          wb_stb_i,
  input logic                          wb_we_i,
  input logic [cpti_pkg::ADR_W-1:0]    wb_adr_i,
  input logic [cpti_pkg::SEL_W-1:0]    wb_sel_i,
  input logic [cpti_pkg::DAT_W-1:0]    wb_dat_i,
  input logic [cpti_pkg::DAT_W-1:0]    wb_dat_o,
  input logic                          wb_ack_o,
  // PCM and group state
  input logic                          pcm_valid_in,
  input logic [cpti_pkg::CHAN_W-1:0]   pcm_chan_in,
  input logic                          pcm_valid_out,
  input logic [cpti_pkg::CHAN_W-1:0]   pcm_chan_out,
  input logic                          pcm_oe,
  input logic [cpti_pkg::GROUPS-1:0]   group_power_on,
  input logic [cpti_pkg::GROUPS-1:0]   group_init_busy,
  // Interrupt pin
  input logic                          irq_n,
  input logic                          irq_oe
);
  import cpti_pkg::*;
  default clocking cb @(posedge clk); endclocking
  // Decodes of acknowledged accesses
  wire  ctl0_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[12:2] == IDX_MAIN_CTL_BASE;
  wire  fifo_rd = wb_ack_o && !wb_we_i && wb_adr_i[12:2] == IDX_IRQ_FIFO;
  // Shadow of the global mask; lags the design by a cycle, hence the margin below
  logic mask_r;
  wire  mask_nxt = ctl0_wr ? wb_dat_i[BIT_GLOBAL_IRQ_MASK] : mask_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_r <= 1'b0;
    end else begin
      mask_r <= mask_nxt;
    end
  end
  rst_park_a: assert property (sys_rst |=> !wb_ack_o && irq_n && !irq_oe && !pcm_oe)
    else $error("outputs not parked in reset");
  oe_run_a: assert property (disable iff (sys_rst) !$past(sys_rst) |-> irq_oe && pcm_oe)
    else $error("pins not driven after reset");
  ack_time_a: assert property (disable iff (sys_rst) $rose(wb_cyc_i && wb_stb_i) |->
    !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o) else $error("ack not in third cycle");
  ack_once_a: assert property (disable iff (sys_rst) wb_ack_o |->
    $past(wb_stb_i, 2) ##1 !wb_ack_o) else $error("ack without request or too long");
  dat_quiet_a: assert property (disable iff (sys_rst) (!wb_ack_o || wb_we_i) |-> wb_dat_o == '0)
    else $error("read data outside read ack");
  fifo_rel_a: assert property (disable iff (sys_rst) fifo_rd |-> irq_n)
    else $error("irq low during fifo read");
  gmask_a: assert property (disable iff (sys_rst) mask_r && $past(mask_r, 3) |-> irq_n)
    else $error("irq low while globally masked");
  init_go_a: assert property (disable iff (sys_rst) (group_power_on & ~$past(group_power_on)) != '0
    |-> ##[0:1] group_init_busy != '0) else $error("no init after power on");
  init_own_a: assert property (disable iff (sys_rst)
    (group_init_busy & ~group_power_on & ~$past(group_power_on)) == '0) else $error("init while off");
  pcm_lat_a: assert property (disable iff (sys_rst) pcm_valid_in |-> ##2
    pcm_valid_out && pcm_chan_out == $past(pcm_chan_in, 2)) else $error("pcm slot latency");
  // Main scenarios reached
  cover property (disable iff (sys_rst) fifo_rd && !wb_dat_o[BIT_FIFO_EMPTY]);
  cover property (disable iff (sys_rst) $fell(irq_n));
  cover property (disable iff (sys_rst) $rose(group_init_busy[3]));
endmodule // cpti_chk

bind cpti_top cpti_chk cpti_chk_inst (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pcm_valid_in(pcm_valid_in),
  .pcm_chan_in(pcm_chan_in), .pcm_valid_out(pcm_valid_out), .pcm_chan_out(pcm_chan_out),
  .pcm_oe(pcm_oe), .group_power_on(group_power_on), .group_init_busy(group_init_busy),
  .irq_n(irq_n), .irq_oe(irq_oe));

// ==== cpti_group_init.sv ====
`timescale 1ns/100ps
// Per-group power-up edge detect and two-frame initialisation timer
module cpti_group_init (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Control
  input  wire logic group_power_on,
  input  wire logic frame_pulse_in,
  // Status
  output logic      init_busy
);
  import cpti_pkg::*;

  logic       power_q_r;   // Registered copy of the power bit
  logic [1:0] frames_r;    // Frame boundaries still to pass
  logic       rise;        // Zero-to-one edge of the power bit

  assign rise = group_power_on & ~power_q_r; // [RULE_22]

  // Edge capture and frame countdown
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_q_r <= 1'b0;
      frames_r  <= '0;
      init_busy <= 1'b0;
    end else begin
      power_q_r <= group_power_on; // [RULE_22]
      if (!group_power_on) begin
        // Power-down aborts an unfinished init
        frames_r  <= '0;
        init_busy <= 1'b0;
      end else if (rise) begin
        frames_r  <= INIT_FRAMES; // [RULE_08]
        init_busy <= 1'b1;
      end else if (init_busy && frame_pulse_in) begin
        frames_r  <= frames_r - 2'h1;
        init_busy <= (frames_r != 2'h1);
      end
    end
  end

endmodule // cpti_group_init

// ==== cpti_host_bfm.sv ====
`timescale 1ns/100ps
// Host processor model: owns the reset pin and runs classic bus cycles
module cpti_host_bfm (
  // Clock
  input  wire logic                       clk,
  // Reset pin, active high at this level
  output logic                            sys_rst,
  // Bus master
  output logic                            wb_cyc_i,
  output logic                            wb_stb_i,
  output logic                            wb_we_i,
  output logic [cpti_pkg::ADR_W-1:0]      wb_adr_i,
  output logic [cpti_pkg::SEL_W-1:0]      wb_sel_i,
  output logic [cpti_pkg::DAT_W-1:0]      wb_dat_i,
  input  wire logic [cpti_pkg::DAT_W-1:0] wb_dat_o,
  input  wire logic                       wb_ack_o
);
  import cpti_pkg::*;
  // Power-up state: reset asserted, bus idle
  initial begin
    sys_rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = '0;
    wb_sel_i = '0;
    wb_dat_i = '0;
  end
  // Reset pulse of n cycles; second resets use 125..375 cycles
  task automatic pulse_rst(input int n);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (n) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  // One cycle; held until ack, address and data lines then show inverted values
  task automatic xfer(input logic we, input logic [SEL_W-1:0] sel, input logic [ADR_W-1:0] adr,
                      input logic [DAT_W-1:0] wd, output logic [DAT_W-1:0] rd);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= we ? wd : ~wd;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_adr_i <= ~adr;
    wb_dat_i <= ~wd;
  endtask
endmodule // cpti_host_bfm

// ==== cpti_mem.sv ====
`timescale 1ns/100ps
// Simple dual-port memory, read data registered, read-before-write
module cpti_mem #(
  parameter int W  = 8,
  parameter int AW = 6
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  // Read port
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);

  logic [W-1:0] mem_r [0:(1<<AW)-1];  // Storage, no reset needed

  // Array write
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // Registered read returns the old word on a same-address write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule // cpti_mem

// ==== cpti_pkg.sv ====
package cpti_pkg;

  // Geometry
  localparam int GROUPS      = 16;
  localparam int CHANNELS    = 32;
  localparam int CHAN_W      = 5;
  localparam int REG_W       = 8;
  localparam int IDX_W       = 11;
  localparam int ADR_W       = 16;
  localparam int DAT_W       = 32;
  localparam int SEL_W       = 4;
  localparam int PCM_W       = 8;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MAIN_CTL_BASE = 11'h400;
  localparam logic [IDX_W-1:0] IDX_MAIN_CTL_LAST = 11'h40f;
  localparam logic [IDX_W-1:0] IDX_IRQ_FIFO      = 11'h410;
  localparam logic [IDX_W-1:0] IDX_TEST          = 11'h411;
  localparam logic [IDX_W-1:0] IDX_CHAN_LAST     = 11'h3ff;
  localparam logic [4:0]       CHAN_STATUS_OFF   = 5'h02;
  localparam int               ADR_IDX_LSB       = 2;

  // Main control register fields
  localparam int BIT_GROUP_POWER_ON  = 0;
  localparam int BIT_TONE_IRQ_MASK_A = 3;
  localparam int BIT_TONE_IRQ_MASK_B = 4;
  localparam int BIT_GLOBAL_IRQ_MASK = 5;

  // Channel status register fields
  localparam int BIT_TONE_PRESENT    = 0;
  localparam int BIT_INIT_BUSY       = 1;

  // Interrupt FIFO read word: channel low, empty flag high
  localparam int BIT_FIFO_EMPTY      = 7;

  // Reset values
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  // Interrupt FIFO: detect plus release for every channel
  localparam int FIFO_AW    = 6;
  localparam int FIFO_DEPTH = 2 * CHANNELS;
  localparam logic [FIFO_AW:0] FIFO_FULL = 7'h40;

  // Frame counts
  localparam logic [1:0] INIT_FRAMES   = 2'h2;
  localparam int         BYPASS_FRAMES = 2;
  localparam int         BYP_AW        = CHAN_W + 1;

  // Bus sequencer, one bit changes per step except ANSWER back to IDLE
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_FETCH  = 2'b01,
    BUS_ANSWER = 2'b11
  } cpti_bus_type;

endpackage

// ==== cpti_top.sv ====
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Summary of operation
// [RULE_01] Host holds reset low at least 100 us
// [RULE_02] Reset parks device, all outputs released
// [RULE_03] Reset zeroes main control, FIFO, test registers
// [RULE_04] Host waits 500 us for clock lock
// [RULE_05] Optional second reset pulse 500-1500 ns
// [RULE_06] Or software reset: power bits on, off
// [RULE_07] Host waits relock, then powers groups individually
// [RULE_08] Power bit rising edge starts group initialisation
// [RULE_09] Host waits two frames before channel setup
// [RULE_10] Powered-down group bypasses PCM, two-frame delay
// [RULE_11] Host clears filter by one-frame bypass
// [RULE_12] Host resets cancellers before progress tones
// [RULE_13] Tone detect and release each raise event
// [RULE_14] Events queue channel numbers in FIFO
// [RULE_15] Interrupt pin releases per read, repulses pending
// [RULE_16] Channel status shows tone disable present
// [RULE_17] Global mask bit 5 suppresses all interrupts
// [RULE_18] Bits 4 and 3 mask cancellers B, A
// [RULE_19] Main control at 400h, FIFO 410h, test 411h
// [RULE_20] Status at offset 02h within 32-byte block
// [RULE_21] FIFO holds 64 events, reports empty
// [RULE_22] Registered power bit copy for edge detect
module cpti_top (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            sys_rst,
  // Wishbone slave
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [cpti_pkg::ADR_W-1:0]      wb_adr_i,
  input  wire logic [cpti_pkg::SEL_W-1:0]      wb_sel_i,
  input  wire logic [cpti_pkg::DAT_W-1:0]      wb_dat_i,
  output logic      [cpti_pkg::DAT_W-1:0]      wb_dat_o,
  output logic                                 wb_ack_o,
  // Frame timing
  input  wire logic                            frame_pulse_in,
  // Tone detector levels, one per channel
  input  wire logic [cpti_pkg::CHANNELS-1:0]   tone_detect_in,
  // PCM sample slots
  input  wire logic                            pcm_valid_in,
  input  wire logic [cpti_pkg::CHAN_W-1:0]     pcm_chan_in,
  input  wire logic [cpti_pkg::PCM_W-1:0]      rin_in,
  input  wire logic [cpti_pkg::PCM_W-1:0]      sin_in,
  input  wire logic [cpti_pkg::PCM_W-1:0]      ec_rout_in,
  input  wire logic [cpti_pkg::PCM_W-1:0]      ec_sout_in,
  output logic                                 pcm_valid_out,
  output logic [cpti_pkg::CHAN_W-1:0]          pcm_chan_out,
  output logic [cpti_pkg::PCM_W-1:0]           rout_out,
  output logic [cpti_pkg::PCM_W-1:0]           sout_out,
  output logic                                 pcm_oe,
  // Group state to the canceller datapath
  output logic [cpti_pkg::GROUPS-1:0]          group_power_on,
  output logic [cpti_pkg::GROUPS-1:0]          group_init_busy,
  // Interrupt pin
  output logic                                 irq_n,
  output logic                                 irq_oe
);
  import cpti_pkg::*;

  // First set bit, used by the event arbiter
  function automatic logic [CHAN_W:0] first_one(input logic [CHANNELS-1:0] v);
    logic [CHAN_W:0] res;
    res = '0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        res = {1'b1, CHAN_W'(i)};
      end
    end
    return res;
  endfunction

  // Mask decode for one channel
  function automatic logic chan_masked(input logic [REG_W-1:0] ctl,
                                       input logic             is_b);
    return is_b ? ctl[BIT_TONE_IRQ_MASK_B] : ctl[BIT_TONE_IRQ_MASK_A];
  endfunction

  // Register state
  logic [REG_W-1:0]    ctl_r [GROUPS];   // Main control registers
  logic [REG_W-1:0]    test_r;           // Test register, storage only
  cpti_bus_type        bus_r;            // Bus sequencer
  logic                we_r;             // Latched direction
  logic [IDX_W-1:0]    idx_r;            // Latched register index
  logic [REG_W-1:0]    wdat_r;           // Latched write byte
  logic                lane_r;           // Low byte lane enabled
  logic                fifo_empty_r;     // FIFO was empty at the read

  // Event and FIFO state
  logic [CHANNELS-1:0] tone_q_r;         // Previous tone levels
  logic [CHANNELS-1:0] pend_r;           // Events awaiting the FIFO
  logic [FIFO_AW-1:0]  wr_ptr_r;
  logic [FIFO_AW-1:0]  rd_ptr_r;
  logic [FIFO_AW:0]    count_r;
  logic [CHAN_W-1:0]   fifo_rdata;

  // Bypass delay state
  logic                bank_r;           // Frame parity selects bank
  logic                byp_valid_r;
  logic [CHAN_W-1:0]   byp_chan_r;
  logic [PCM_W-1:0]    ec_rout_r;
  logic [PCM_W-1:0]    ec_sout_r;
  logic [2*PCM_W-1:0]  byp_rdata;

  // Bus decode
  wire logic [IDX_W-1:0] idx      = wb_adr_i[ADR_IDX_LSB +: IDX_W];
  wire logic             req      = wb_cyc_i & wb_stb_i & (bus_r == BUS_IDLE) & ~wb_ack_o;
  wire logic             hit_fifo = (idx == IDX_IRQ_FIFO);
  wire logic             fifo_pop = req & ~wb_we_i & hit_fifo & (count_r != '0); // [RULE_14]
  wire logic             apply    = (bus_r == BUS_FETCH);
  wire logic             is_ctl   = (idx_r >= IDX_MAIN_CTL_BASE) &&
                                    (idx_r <= IDX_MAIN_CTL_LAST); // [RULE_19]
  wire logic             is_chan  = (idx_r <= IDX_CHAN_LAST);
  wire logic [3:0]       ctl_sel  = idx_r[3:0];
  wire logic [CHAN_W-1:0] st_chan = idx_r[9:5];
  wire logic             is_stat  = is_chan && (idx_r[4:0] == CHAN_STATUS_OFF); // [RULE_20]
  wire logic             gmask    = ctl_r[0][BIT_GLOBAL_IRQ_MASK]; // [RULE_17]

  // Event detection and arbitration
  wire logic [CHANNELS-1:0] tone_chg = tone_detect_in ^ tone_q_r; // [RULE_13]
  logic      [CHANNELS-1:0] tone_ok;
  wire logic [CHAN_W:0]     pick     = first_one(pend_r);
  wire logic                push     = pick[CHAN_W] && (count_r != FIFO_FULL); // [RULE_21]
  wire logic [CHANNELS-1:0] grant    = push ? (CHANNELS'(1) << pick[CHAN_W-1:0]) : '0;
  wire logic                fifo_rd_answer = apply & ~we_r & (idx_r == IDX_IRQ_FIFO);

  // Per-channel masks
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      tone_ok[c] = ~gmask & ~chan_masked(ctl_r[c/2], c[0]); // [RULE_18] [RULE_17]
    end
  end

  // Group outputs through one register after the control flops
  always_ff @(posedge clk) begin
    for (int g = 0; g < GROUPS; g++) begin
      group_power_on[g] <= sys_rst ? 1'b0 : ctl_r[g][BIT_GROUP_POWER_ON];
    end
  end

  // Initialisation timers, one per group
  for (genvar g = 0; g < GROUPS; g++) begin : g_init
    cpti_group_init u_init (
      .clk            (clk),
      .sys_rst        (sys_rst),
      .group_power_on (ctl_r[g][BIT_GROUP_POWER_ON]),
      .frame_pulse_in (frame_pulse_in),
      .init_busy      (group_init_busy[g])
    );
  end

  // Bus sequencer: take, fetch, answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_r  <= BUS_IDLE;
      we_r   <= 1'b0;
      idx_r  <= '0;
      wdat_r <= '0;
      lane_r <= 1'b0;
      fifo_empty_r <= 1'b0;
    end else begin
      case (bus_r)
        BUS_IDLE: begin
          if (req) begin
            bus_r  <= BUS_FETCH;
            we_r   <= wb_we_i;
            idx_r  <= idx;
            wdat_r <= wb_dat_i[REG_W-1:0];
            lane_r <= wb_sel_i[0];
            fifo_empty_r <= (count_r == '0);
          end
        end
        BUS_FETCH:  bus_r <= BUS_ANSWER;
        BUS_ANSWER: bus_r <= BUS_IDLE;
        default:    bus_r <= BUS_IDLE;
      endcase
    end
  end

  // Answer: ack and read data for one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= apply;
      if (apply && !we_r) begin
        if (is_ctl) begin
          wb_dat_o <= DAT_W'(ctl_r[ctl_sel]);
        end else if (idx_r == IDX_IRQ_FIFO) begin
          // Empty flag instead of a stale channel number
          wb_dat_o <= fifo_empty_r ? DAT_W'(1) << BIT_FIFO_EMPTY
                                   : DAT_W'(fifo_rdata); // [RULE_21] [RULE_14]
        end else if (idx_r == IDX_TEST) begin
          wb_dat_o <= DAT_W'(test_r);
        end else if (is_stat) begin
          wb_dat_o <= (DAT_W'(tone_q_r[st_chan]) << BIT_TONE_PRESENT) |
                      (DAT_W'(group_init_busy[st_chan[CHAN_W-1:1]]) << BIT_INIT_BUSY); // [RULE_16]
        end else begin
          // Unmapped and other channel registers read zero
          wb_dat_o <= '0;
        end
      end else begin
        wb_dat_o <= '0;
      end
    end
  end

  // Register writes land as the ack rises
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int g = 0; g < GROUPS; g++) begin
        ctl_r[g] <= REG_RESET; // [RULE_03]
      end
      test_r <= REG_RESET; // [RULE_03]
    end else if (apply && we_r && lane_r) begin
      if (is_ctl) begin
        ctl_r[ctl_sel] <= wdat_r;
      end else if (idx_r == IDX_TEST) begin
        test_r <= wdat_r;
      end
    end
  end

  // Pending events; a new event beats the grant that clears it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tone_q_r <= '0;
      pend_r   <= '0;
    end else begin
      tone_q_r <= tone_detect_in;
      pend_r   <= (pend_r & ~grant) | (tone_chg & tone_ok); // [RULE_13]
    end
  end

  // FIFO pointers and fill count
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0; // [RULE_03]
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (fifo_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (FIFO_AW+1)'(push) - (FIFO_AW+1)'(fifo_pop);
    end
  end

  // Channel-number queue
  cpti_mem #(.W(CHAN_W), .AW(FIFO_AW)) u_fifo_mem (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (push),
    .wr_addr (wr_ptr_r),
    .wr_data (pick[CHAN_W-1:0]), // [RULE_14]
    .rd_en   (fifo_pop),
    .rd_addr (rd_ptr_r),
    .rd_data (fifo_rdata)
  );

  // Interrupt pin: high during reset-release and on each FIFO read answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_n  <= 1'b1;
      irq_oe <= 1'b0; // [RULE_02]
    end else begin
      irq_oe <= 1'b1;
      irq_n  <= ~((count_r != '0) & ~gmask & ~fifo_rd_answer); // [RULE_15] [RULE_17]
    end
  end

  // Frame parity for the two-bank delay line
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bank_r <= 1'b0;
    end else if (frame_pulse_in) begin
      bank_r <= ~bank_r;
    end
  end

  // Bypass store: a slot read before it is rewritten is two frames old
  cpti_mem #(.W(2*PCM_W), .AW(BYP_AW)) u_byp_mem (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (pcm_valid_in),
    .wr_addr ({bank_r, pcm_chan_in}),
    .wr_data ({rin_in, sin_in}),
    .rd_en   (pcm_valid_in),
    .rd_addr ({bank_r, pcm_chan_in}),
    .rd_data (byp_rdata)
  ); // [RULE_10]

  // Align canceller output with the delayed bypass word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      byp_valid_r <= 1'b0;
      byp_chan_r  <= '0;
      ec_rout_r   <= '0;
      ec_sout_r   <= '0;
    end else begin
      byp_valid_r <= pcm_valid_in;
      byp_chan_r  <= pcm_chan_in;
      ec_rout_r   <= ec_rout_in;
      ec_sout_r   <= ec_sout_in;
    end
  end

  // PCM outputs; a powered-down group takes the delayed input
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pcm_valid_out <= 1'b0;
      pcm_chan_out  <= '0;
      rout_out      <= '0;
      sout_out      <= '0;
      pcm_oe        <= 1'b0; // [RULE_02]
    end else begin
      pcm_oe        <= 1'b1;
      pcm_valid_out <= byp_valid_r;
      pcm_chan_out  <= byp_chan_r;
      if (!ctl_r[byp_chan_r[CHAN_W-1:1]][BIT_GROUP_POWER_ON]) begin
        rout_out <= byp_rdata[2*PCM_W-1:PCM_W]; // [RULE_10]
        sout_out <= byp_rdata[PCM_W-1:0];       // [RULE_10]
      end else begin
        rout_out <= ec_rout_r;
        sout_out <= ec_sout_r;
      end
    end
  end

endmodule // cpti_top

// ==== tb.sv ====
`timescale 1ns/100ps
// Self-checking bench: reset, power-up, bypass, tone interrupts, masks
module tb;
  import cpti_pkg::*;
  logic              clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADR_W-1:0]  wb_adr_i;
  logic [SEL_W-1:0]  wb_sel_i;
  logic [DAT_W-1:0]  wb_dat_i, wb_dat_o, rdat;
  logic              frame_pulse_in, pcm_valid_in, pcm_valid_out, pcm_oe, irq_n, irq_oe;
  logic [CHANNELS-1:0] tone_detect_in;
  logic [CHAN_W-1:0] pcm_chan_in, pcm_chan_out;
  logic [PCM_W-1:0]  rin_in, sin_in, ec_rout_in, ec_sout_in, rout_out, sout_out;
  logic [GROUPS-1:0] group_power_on, group_init_busy;
  int                err_total, num_checks;
  cpti_top cpti_top_inst (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_pulse_in(frame_pulse_in),
    .tone_detect_in(tone_detect_in), .pcm_valid_in(pcm_valid_in), .pcm_chan_in(pcm_chan_in),
    .rin_in(rin_in), .sin_in(sin_in), .ec_rout_in(ec_rout_in), .ec_sout_in(ec_sout_in),
    .pcm_valid_out(pcm_valid_out), .pcm_chan_out(pcm_chan_out), .rout_out(rout_out),
    .sout_out(sout_out), .pcm_oe(pcm_oe), .group_power_on(group_power_on),
    .group_init_busy(group_init_busy), .irq_n(irq_n), .irq_oe(irq_oe));
  cpti_host_bfm cpti_host_bfm_inst (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Byte-lane writes and reads; control reg g at 1000h+4g, status of c at 80h*c+8
  task automatic wr(input logic [ADR_W-1:0] a, input logic [7:0] d);
    cpti_host_bfm_inst.xfer(1'b1, 4'h1, a, {24'h0, d}, rdat);
  endtask
  task automatic rd(input logic [ADR_W-1:0] a);
    cpti_host_bfm_inst.xfer(1'b0, 4'h1, a, '0, rdat);
  endtask
  task automatic frame();
    @(posedge clk) frame_pulse_in <= 1'b1;
    @(posedge clk) frame_pulse_in <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Bounded wait for the interrupt pin level
  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 12 && irq_n !== lvl; i++) @(posedge clk);
    #1 check({31'h0, irq_n}, {31'h0, lvl});
  endtask
  task automatic set_tone(input logic [CHANNELS-1:0] t);
    @(posedge clk) tone_detect_in <= t;
  endtask
  // One PCM slot; outputs sampled two cycles on
  task automatic slot(input logic [7:0] r, input logic [7:0] s);
    @(posedge clk) {pcm_valid_in, pcm_chan_in, rin_in, sin_in} <= {1'b1, 5'h0, r, s};
    {ec_rout_in, ec_sout_in} <= ~{r, s};
    @(posedge clk) pcm_valid_in <= 1'b0;
    @(posedge clk) #1;
  endtask
  task automatic t_reset();
    wr(16'h1044, 8'ha5);
    cpti_host_bfm_inst.xfer(1'b1, 4'he, 16'h1044, 32'h5a, rdat);
    rd(16'h1044);
    check(rdat, 32'ha5);
    wr(16'h1014, 8'h18);
    fork
      cpti_host_bfm_inst.pulse_rst(200);
      begin
        repeat (4) @(posedge clk);
        #1 check({28'h0, irq_n, irq_oe, pcm_oe, wb_ack_o}, 32'h8);
      end
    join
    for (int g = 0; g < 18; g++) begin
      rd(16'(16'h1000 + 4 * g));
      check(rdat, (g == 16) ? 32'h80 : 32'h0);
    end
  endtask
  task automatic t_power();
    for (int g = 0; g < 16; g++) wr(16'(16'h1000 + 4 * g), 8'h01);
    repeat (2) @(posedge clk);
    #1 check({group_power_on, group_init_busy}, 32'hffffffff);
    rd(16'h0088);
    check({31'h0, rdat[BIT_INIT_BUSY]}, 32'h1);
    frame();
    check({16'h0, group_init_busy}, 32'hffff);
    frame();
    check({16'h0, group_init_busy}, 32'h0);
    for (int g = 0; g < 16; g++) wr(16'(16'h1000 + 4 * g), 8'h00);
    wr(16'h100c, 8'h01);
    repeat (2) @(posedge clk);
    #1 check({group_power_on, group_init_busy}, 32'h00080008);
    frame();
    frame();
    wr(16'h100c, 8'h01);
    repeat (2) @(posedge clk);
    #1 check({16'h0, group_init_busy}, 32'h0);
  endtask
  task automatic t_bypass();
    slot(8'h11, 8'h22);
    frame();
    frame();
    slot(8'h33, 8'h44);
    check({16'h0, rout_out, sout_out}, 32'h1122);
    wr(16'h1000, 8'h01);
    slot(8'h55, 8'h66);
    check({16'h0, rout_out, sout_out}, 32'haa99);
    wr(16'h1000, 8'h00);
  endtask
  task automatic t_irq();
    set_tone(32'h60);
    wait_irq(1'b0);
    rd(16'h1040);
    check(rdat, 32'h5);
    wait_irq(1'b0);
    rd(16'h1040);
    check(rdat, 32'h6);
    wait_irq(1'b1);
    rd(16'h0288);
    check({31'h0, rdat[BIT_TONE_PRESENT]}, 32'h1);
    set_tone(32'h20);
    wait_irq(1'b0);
    rd(16'h1040);
    check(rdat, 32'h6);
    rd(16'h0308);
    check({31'h0, rdat[BIT_TONE_PRESENT]}, 32'h0);
    set_tone(32'h0);
    wait_irq(1'b0);
    rd(16'h1040);
    check(rdat, 32'h5);
  endtask
  task automatic t_mask();
    wr(16'h1008, 8'h10);
    wr(16'h100c, 8'h08);
    set_tone(32'h60);
    repeat (12) @(posedge clk);
    #1 check({31'h0, irq_n}, 32'h1);
    rd(16'h1040);
    check(rdat, 32'h80);
    set_tone(32'hf0);
    wait_irq(1'b0);
    rd(16'h1040);
    check(rdat, 32'h4);
    rd(16'h1040);
    check(rdat, 32'h7);
    set_tone(32'hf1);
    wr(16'h1000, 8'h20);
    set_tone(32'hf0);
    repeat (12) @(posedge clk);
    #1 check({31'h0, irq_n}, 32'h1);
    rd(16'h1040);
    check(rdat, 32'h0);
    rd(16'h1040);
    check(rdat, 32'h80);
  endtask
  // Main sequence
  initial begin
    err_total = 0;
    num_checks = 0;
    {frame_pulse_in, pcm_valid_in, pcm_chan_in, rin_in, sin_in} = '0;
    {ec_rout_in, ec_sout_in, tone_detect_in} = '0;
    cpti_host_bfm_inst.pulse_rst(7);
    repeat (8) @(posedge clk);
    t_reset();
    t_power();
    t_bypass();
    t_irq();
    t_mask();
    conclude();
  end
  // Watchdog
  initial begin
    #100000;
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    conclude();
  end
endmodule // tb
